// ---- rtl/ffo_defs.vh ----
`ifndef FFO_DEFS_VH
`define FFO_DEFS_VH

// storage geometry
`define FFO_DEPTH          1024
`define FFO_WIDTH          18
`define FFO_AW             10
`define FFO_CW             11
`define FFO_XW             9

// almost-flag offset and level thresholds
`define FFO_DEFAULT_X      9'h100
`define FFO_HALF_LEVEL     11'h201
`define FFO_FULL_LEVEL     11'h400
`define FFO_ALMOST_HI_BASE 11'h401

// register byte offsets
`define FFO_ADDR_STATUS    8'h00
`define FFO_ADDR_MASK      8'h04
`define FFO_ADDR_LEVEL     8'h08
`define FFO_ADDR_OFFSET    8'h0c
`define FFO_ADDR_MSB       7

// status / mask bit layout
`define FFO_EV_W           4
`define FFO_EV_FULL        0
`define FFO_EV_EMPTY       1
`define FFO_EV_HALF        2
`define FFO_EV_ALMOST      3

// level register field positions
`define FFO_LVL_IR         16
`define FFO_LVL_OR         17
`define FFO_LVL_HF         18
`define FFO_LVL_AF         19

`define FFO_MASK_RESET     4'h0

`endif

// ---- rtl/ffo_mem.v ----
`timescale 1ns/1ps
`include "ffo_defs.vh"

module ffo_mem #(
  parameter DEPTH = `FFO_DEPTH,
  parameter WIDTH = `FFO_WIDTH,
  parameter AW    = `FFO_AW
) (
  input  wire             clk,     // system clock
  input  wire             rst_n,   // async reset, active low
  input  wire             wr_en,   // store one word
  input  wire [AW-1:0]    wr_addr, // write slot
  input  wire [WIDTH-1:0] wr_data, // word to store
  input  wire             rd_en,   // unload one word
  input  wire [AW-1:0]    rd_addr, // read slot
  output reg  [WIDTH-1:0] rd_data  // registered word out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- rtl/ffo_flags.v ----
`timescale 1ns/1ps
`include "ffo_defs.vh"

module ffo_flags #(
  parameter CW = `FFO_CW,
  parameter XW = `FFO_XW
) (
  input  wire [CW-1:0] count,     // stored word count
  input  wire [XW-1:0] offset,    // active almost offset
  output wire          full,      // count at capacity
  output wire          empty,     // count zero
  output wire          half_full, // half-full level
  output wire          almost     // almost-full/almost-empty level
);

  wire [CW-1:0] lo_lim;
  wire [CW-1:0] hi_lim;

  assign lo_lim    = {{(CW-XW){1'b0}}, offset} + {{(CW-1){1'b0}}, 1'b1};
  assign hi_lim    = `FFO_ALMOST_HI_BASE - {{(CW-XW){1'b0}}, offset};
  assign full      = (count == `FFO_FULL_LEVEL);
  assign empty     = (count == {CW{1'b0}});
  assign half_full = (count >= `FFO_HALF_LEVEL);
  assign almost    = (count <= lo_lim) || (count >= hi_lim);

endmodule

// ---- rtl/ffo_top.v ----
`timescale 1ns/1ps
`include "ffo_defs.vh"

// Function
// - store up to 1024 words of 18 bits from the data inputs
// - read data equals written data bit for bit, no inversion
// - write side and read side each run on their own clock
// - almost flag high when count <= offset+1 or >= 1025-offset
// - almost flag low when count between offset+2 and 1024-offset
// - with no programmed offset the almost offset is 256
// - offset-define falling edge captures data inputs as stored offset
// - offset carried on data bits 0 to 8 at that falling edge
// - offset choice is re-made on every reset cycle
// - reset release with offset-define low adopts captured offset
// - offset-define high through reset reverts offset to 256
// - half-full high at 513 or more words, low at 512 or fewer
// - reset clears pointers, ready and half flags low, almost high
// - write on write-clock rise only with input-ready and both enables
// - read on read-clock rise with output-ready, output enable, enables
module ffo_top #(
  parameter DEPTH = `FFO_DEPTH,
  parameter WIDTH = `FFO_WIDTH,
  parameter AW    = `FFO_AW,
  parameter CW    = `FFO_CW,
  parameter XW    = `FFO_XW
) (
  input  wire             CLOCK,             // system clock, 125 MHz
  input  wire             RST_N,             // async reset, active low
  input  wire             FIFO_RESET_N,      // fifo reset pin, active low
  input  wire             WRITE_SIDE_CLOCK,  // write-side clock pin
  input  wire             READ_SIDE_CLOCK,   // read-side clock pin
  input  wire [WIDTH-1:0] WRITE_DATA_IN,     // data inputs
  input  wire             WRITE_ENABLE_A,    // write enable a
  input  wire             WRITE_ENABLE_B,    // write enable b
  input  wire             READ_ENABLE_A,     // read enable a
  input  wire             READ_ENABLE_B,     // read enable b
  input  wire             OUTPUT_ENABLE,     // output drive enable
  input  wire             OFFSET_DEFINE_N,   // offset define, active low
  output wire [WIDTH-1:0] READ_DATA_OUT,     // data outputs
  output reg              READ_DATA_OE,      // data output drive enable
  output reg              INPUT_READY_FLAG,  // not full
  output reg              OUTPUT_READY_FLAG, // not empty
  output reg              HALF_FULL_FLAG,    // half full
  output reg              ALMOST_LEVEL_FLAG, // almost full/empty
  output reg              IRQ,               // interrupt, active high
  input  wire             HSEL,              // ahb select
  input  wire [31:0]      HADDR,             // ahb address
  input  wire [1:0]       HTRANS,            // ahb transfer type
  input  wire             HWRITE,            // ahb write
  input  wire [2:0]       HSIZE,             // ahb size
  input  wire [31:0]      HWDATA,            // ahb write data
  input  wire             HREADY,            // ahb bus ready
  output reg  [31:0]      HRDATA,            // ahb read data
  output reg              HREADYOUT,         // ahb slave ready
  output reg              HRESP              // ahb response
);

  // pin edge detection (pins are synchronous to CLOCK)
  reg           wclk_q;
  reg           rclk_q;
  reg           daf_q;
  reg           frst_q;
  reg  [AW-1:0] wptr_q;
  reg  [AW-1:0] rptr_q;
  reg  [CW-1:0] count_q;
  reg  [CW-1:0] count_d;
  reg  [XW-1:0] stored_x_q;
  reg  [XW-1:0] active_x_q;
  reg  [`FFO_EV_W-1:0] status_q;
  reg  [`FFO_EV_W-1:0] status_d;
  reg  [`FFO_EV_W-1:0] mask_q;
  reg           dp_wr_q;
  reg  [`FFO_ADDR_MSB:0] dp_addr_q;

  wire          wclk_rise;
  wire          rclk_rise;
  wire          wr_fire;
  wire          rd_fire;
  wire          f_full;
  wire          f_empty;
  wire          f_half;
  wire          f_almost;
  wire          ahb_go;
  wire          ahb_rd;
  wire [`FFO_ADDR_MSB:0] ahb_addr;
  wire [`FFO_EV_W-1:0]   ev;
  wire [`FFO_EV_W-1:0]   rd_clr;

  function reg_hit;
    input [`FFO_ADDR_MSB:0] a;
    input [`FFO_ADDR_MSB:0] r;
    begin
      reg_hit = (a == r);
    end
  endfunction

  assign wclk_rise = WRITE_SIDE_CLOCK & ~wclk_q;
  assign rclk_rise = READ_SIDE_CLOCK & ~rclk_q;
  assign wr_fire   = frst_q & wclk_rise & INPUT_READY_FLAG
                   & WRITE_ENABLE_A & WRITE_ENABLE_B;
  assign rd_fire   = frst_q & rclk_rise & OUTPUT_READY_FLAG & OUTPUT_ENABLE
                   & READ_ENABLE_A & READ_ENABLE_B;

  ffo_mem #(
    .DEPTH (DEPTH),
    .WIDTH (WIDTH),
    .AW    (AW)
  ) u_mem (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .wr_en   (wr_fire),
    .wr_addr (wptr_q),
    .wr_data (WRITE_DATA_IN),
    .rd_en   (rd_fire),
    .rd_addr (rptr_q),
    .rd_data (READ_DATA_OUT)
  );

  // both sides update one count in the single clock domain
  always @* begin
    count_d = count_q;
    if (wr_fire && !rd_fire) begin
      count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
    end else if (rd_fire && !wr_fire) begin
      count_d = count_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  ffo_flags #(
    .CW (CW),
    .XW (XW)
  ) u_flags (
    .count     (count_d),
    .offset    (active_x_q),
    .full      (f_full),
    .empty     (f_empty),
    .half_full (f_half),
    .almost    (f_almost)
  );

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      daf_q  <= 1'b1;
      frst_q <= 1'b0;
    end else begin
      wclk_q <= WRITE_SIDE_CLOCK;
      rclk_q <= READ_SIDE_CLOCK;
      daf_q  <= OFFSET_DEFINE_N;
      frst_q <= FIFO_RESET_N;
    end
  end

  // almost offset capture and selection
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stored_x_q <= `FFO_DEFAULT_X;
      active_x_q <= `FFO_DEFAULT_X;
    end else begin
      if (daf_q && !OFFSET_DEFINE_N) begin
        stored_x_q <= WRITE_DATA_IN[XW-1:0];
      end
      if (FIFO_RESET_N && !frst_q) begin
        if (!OFFSET_DEFINE_N) begin
          active_x_q <= stored_x_q;
        end else begin
          active_x_q <= `FFO_DEFAULT_X;
        end
      end
    end
  end

  // pointers, count and pin flags
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wptr_q            <= {AW{1'b0}};
      rptr_q            <= {AW{1'b0}};
      count_q           <= {CW{1'b0}};
      INPUT_READY_FLAG  <= 1'b0;
      OUTPUT_READY_FLAG <= 1'b0;
      HALF_FULL_FLAG    <= 1'b0;
      ALMOST_LEVEL_FLAG <= 1'b1;
      READ_DATA_OE      <= 1'b0;
    end else if (!FIFO_RESET_N) begin
      wptr_q            <= {AW{1'b0}};
      rptr_q            <= {AW{1'b0}};
      count_q           <= {CW{1'b0}};
      INPUT_READY_FLAG  <= 1'b0;
      OUTPUT_READY_FLAG <= 1'b0;
      HALF_FULL_FLAG    <= 1'b0;
      ALMOST_LEVEL_FLAG <= 1'b1;
      READ_DATA_OE      <= OUTPUT_ENABLE;
    end else begin
      if (wr_fire) begin
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (rd_fire) begin
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      count_q           <= count_d;
      INPUT_READY_FLAG  <= ~f_full;
      OUTPUT_READY_FLAG <= ~f_empty;
      HALF_FULL_FLAG    <= f_half;
      ALMOST_LEVEL_FLAG <= f_almost;
      READ_DATA_OE      <= OUTPUT_ENABLE;
    end
  end

  // register bus
  assign ahb_go   = HSEL & HTRANS[1] & HREADY;
  assign ahb_rd   = ahb_go & ~HWRITE;
  assign ahb_addr = HADDR[`FFO_ADDR_MSB:0];
  assign rd_clr   = (ahb_rd && reg_hit(ahb_addr, `FFO_ADDR_STATUS)) ?
                    status_q : {`FFO_EV_W{1'b0}};

  // events are rising edges of the level conditions
  assign ev[`FFO_EV_FULL]   = f_full & INPUT_READY_FLAG & frst_q;
  assign ev[`FFO_EV_EMPTY]  = f_empty & OUTPUT_READY_FLAG & frst_q;
  assign ev[`FFO_EV_HALF]   = f_half & ~HALF_FULL_FLAG & frst_q;
  assign ev[`FFO_EV_ALMOST] = f_almost & ~ALMOST_LEVEL_FLAG & frst_q;

  // a new event wins over a read clear in the same cycle
  always @* begin
    status_d = (status_q & ~rd_clr) | ev;
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      status_q  <= {`FFO_EV_W{1'b0}};
      mask_q    <= `FFO_MASK_RESET;
      dp_wr_q   <= 1'b0;
      dp_addr_q <= {(`FFO_ADDR_MSB+1){1'b0}};
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      IRQ       <= 1'b0;
    end else begin
      status_q  <= status_d;
      IRQ       <= |(status_d & mask_q);
      dp_wr_q   <= ahb_go & HWRITE;
      dp_addr_q <= ahb_addr;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (dp_wr_q && reg_hit(dp_addr_q, `FFO_ADDR_MASK)) begin
        mask_q <= HWDATA[`FFO_EV_W-1:0];
      end
      if (ahb_rd) begin
        HRDATA <= 32'h0000_0000;
        if (reg_hit(ahb_addr, `FFO_ADDR_STATUS)) begin
          HRDATA[`FFO_EV_W-1:0] <= status_q;
        end else if (reg_hit(ahb_addr, `FFO_ADDR_MASK)) begin
          HRDATA[`FFO_EV_W-1:0] <= mask_q;
        end else if (reg_hit(ahb_addr, `FFO_ADDR_LEVEL)) begin
          HRDATA[CW-1:0]         <= count_q;
          HRDATA[`FFO_LVL_IR]    <= INPUT_READY_FLAG;
          HRDATA[`FFO_LVL_OR]    <= OUTPUT_READY_FLAG;
          HRDATA[`FFO_LVL_HF]    <= HALF_FULL_FLAG;
          HRDATA[`FFO_LVL_AF]    <= ALMOST_LEVEL_FLAG;
        end else if (reg_hit(ahb_addr, `FFO_ADDR_OFFSET)) begin
          HRDATA[XW-1:0]         <= active_x_q;
          HRDATA[XW+15:16]       <= stored_x_q;
        end
      end
    end
  end

endmodule

// ---- testbench/ffo_side_clk.sv ----
`timescale 1ns/1ps
module ffo_side_clk (
  input  wire clk, // system clock
  output wire wsc, // write-side clock, period 4
  output wire rsc  // read-side clock, period 6
);
  reg  [1:0] wcnt_q = 2'h0;
  reg  [2:0] rcnt_q = 3'h0;
  wire [2:0] rcnt_d = (rcnt_q == 3'h5) ? 3'h0 : rcnt_q + 3'h1;
  // free-running, also through reset, at unrelated rates
  always @(posedge clk) begin
    wcnt_q <= wcnt_q + 2'h1;
    rcnt_q <= rcnt_d;
  end
  assign wsc = wcnt_q[1];
  assign rsc = rcnt_q > 3'h2;
endmodule

// ---- testbench/ffo_checker.sv ----
`timescale 1ns/1ps
module ffo_checker #(
  parameter WIDTH = 18
) (
  input wire             CLOCK,             // clock
  input wire             RST_N,             // reset
  input wire             FIFO_RESET_N,      // fifo reset
  input wire             WRITE_SIDE_CLOCK,  // write clock
  input wire             READ_SIDE_CLOCK,   // read clock
  input wire [WIDTH-1:0] WRITE_DATA_IN,     // data in, low bits offset
  input wire             OFFSET_DEFINE_N,   // offset define
  input wire             WRITE_ENABLE_A,    // write enable
  input wire             WRITE_ENABLE_B,    // write enable
  input wire             READ_ENABLE_A,     // read enable
  input wire             READ_ENABLE_B,     // read enable
  input wire             OUTPUT_ENABLE,     // output enable
  input wire [WIDTH-1:0] READ_DATA_OUT,     // read word
  input wire             INPUT_READY_FLAG,  // not full
  input wire             OUTPUT_READY_FLAG, // not empty
  input wire             HALF_FULL_FLAG,    // half full
  input wire             ALMOST_LEVEL_FLAG  // almost level
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // offset the flags should be using, rebuilt from the pins
  logic [8:0] x_stored_q;
  logic [8:0] x_active_q;
  logic       dafn_q;
  logic       frst_q;
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      x_stored_q <= 9'h100;
      x_active_q <= 9'h100;
      dafn_q     <= 1'b1;
      frst_q     <= 1'b0;
    end else begin
      dafn_q <= OFFSET_DEFINE_N;
      frst_q <= FIFO_RESET_N;
      if (dafn_q && !OFFSET_DEFINE_N)
        x_stored_q <= WRITE_DATA_IN[8:0];
      if (FIFO_RESET_N && !frst_q)
        x_active_q <= OFFSET_DEFINE_N ? 9'h100 : x_stored_q;
    end
  end

  a_reset_flags: assert property (!FIFO_RESET_N |=>
    !INPUT_READY_FLAG && !OUTPUT_READY_FLAG && !HALF_FULL_FLAG
    && ALMOST_LEVEL_FLAG) else $error("flags not reset");
  a_ready_return: assert property ($rose(FIFO_RESET_N) |->
    ##[1:3] INPUT_READY_FLAG) else $error("input ready late");
  a_full_levels: assert property ($fell(INPUT_READY_FLAG)
    && $past(FIFO_RESET_N) |-> HALF_FULL_FLAG
    && (ALMOST_LEVEL_FLAG == (x_active_q != 9'h000)))
    else $error("full without level flags");
  a_full_cause: assert property ($fell(INPUT_READY_FLAG)
    && $past(FIFO_RESET_N) |-> $past(WRITE_SIDE_CLOCK)
    && $past(WRITE_ENABLE_A) && $past(WRITE_ENABLE_B))
    else $error("full without write");
  a_empty_almost: assert property (!OUTPUT_READY_FLAG
    |-> ALMOST_LEVEL_FLAG) else $error("empty but almost low");
  a_half_ready: assert property (HALF_FULL_FLAG
    |-> OUTPUT_READY_FLAG) else $error("half full but empty");
  a_read_hold: assert property (!(READ_SIDE_CLOCK
    && !$past(READ_SIDE_CLOCK) && OUTPUT_READY_FLAG && OUTPUT_ENABLE
    && READ_ENABLE_A && READ_ENABLE_B) |=> $stable(READ_DATA_OUT))
    else $error("read data moved without a read");
  a_write_gate: assert property ($rose(OUTPUT_READY_FLAG)
    |-> $past(WRITE_SIDE_CLOCK) && $past(WRITE_ENABLE_A)
    && $past(WRITE_ENABLE_B) && $past(INPUT_READY_FLAG))
    else $error("word stored without a write");

  c_full: cover property (!INPUT_READY_FLAG && FIFO_RESET_N);
  c_half: cover property ($rose(HALF_FULL_FLAG));
  c_drain: cover property ($fell(OUTPUT_READY_FLAG));
endmodule

bind ffo_top ffo_checker #(.WIDTH(WIDTH)) i_ffo_checker (
  .CLOCK, .RST_N, .FIFO_RESET_N, .WRITE_SIDE_CLOCK, .READ_SIDE_CLOCK,
  .WRITE_DATA_IN, .OFFSET_DEFINE_N,
  .WRITE_ENABLE_A, .WRITE_ENABLE_B, .READ_ENABLE_A, .READ_ENABLE_B,
  .OUTPUT_ENABLE, .READ_DATA_OUT, .INPUT_READY_FLAG, .OUTPUT_READY_FLAG,
  .HALF_FULL_FLAG, .ALMOST_LEVEL_FLAG);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'h0, rst_n = 1'h0, frst_n = 1'h0, dafn = 1'h1;
  logic        wea = 1'h0, web = 1'h0, rea = 1'h0, reb = 1'h0, oe = 1'h0;
  logic        hsel = 1'h0, hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [17:0] wd = 18'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, seed = 32'h413688d4;
  logic [17:0] q[$];
  wire         wsc, rsc, irf, orf, hff, alf, irq, hro, oeo, hrsp;
  wire  [17:0] rdo;
  wire  [31:0] hrdata;
  int          err_count = 0, num_checks = 0, x = 256;

  always #4 clk = ~clk;

  ffo_side_clk i_ffo_side_clk (.clk(clk), .wsc(wsc), .rsc(rsc));
  ffo_top i_ffo_top (
    .CLOCK(clk), .RST_N(rst_n), .FIFO_RESET_N(frst_n),
    .WRITE_SIDE_CLOCK(wsc), .READ_SIDE_CLOCK(rsc), .WRITE_DATA_IN(wd),
    .WRITE_ENABLE_A(wea), .WRITE_ENABLE_B(web), .READ_ENABLE_A(rea),
    .READ_ENABLE_B(reb), .OUTPUT_ENABLE(oe), .OFFSET_DEFINE_N(dafn),
    .READ_DATA_OUT(rdo), .READ_DATA_OE(oeo), .INPUT_READY_FLAG(irf),
    .OUTPUT_READY_FLAG(orf), .HALF_FULL_FLAG(hff), .ALMOST_LEVEL_FLAG(alf),
    .IRQ(irq), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro),
    .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hrsp));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected {half, almost, input ready, output ready} for n words
  function automatic logic [3:0] flg(input int n, input int xo);
    flg = {n >= 513, n <= xo + 1 || n >= 1025 - xo, n < 1024, n > 0};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hro !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hro !== 1'h1) @(posedge clk);
    r = hrdata;
    chk(hrsp, 1'h0);
  endtask

  // one write or read on the next rise of its side clock
  task xfer(input logic rd, input logic [17:0] d);
    logic tk;
    wd <= d;
    {wea, web} <= {2{!rd}};
    {rea, reb, oe} <= {3{rd}};
    @(negedge clk);
    while ((rd ? rsc : wsc) !== 1'h0) @(negedge clk);
    while ((rd ? rsc : wsc) !== 1'h1) @(negedge clk);
    tk = rd ? orf : irf;
    @(posedge clk);
    {wea, web, rea, reb, oe} <= 5'h0;
    if (tk && !rd)
      q.push_back(d);
    @(negedge clk);
    if (tk && rd)
      chk(rdo, q.pop_front());
    chk({hff, alf, irf, orf}, flg(q.size(), x));
    chk(oeo, rd);
    @(posedge clk);
  endtask

  task prog(input logic dn);
    dafn <= dn;
    @(posedge clk);
    frst_n <= 1'h0;
    repeat (30) @(posedge clk);
    frst_n <= 1'h1;
    q.delete();
    repeat (3) @(posedge clk);
    ahb(1'h0, 32'hc, 32'h0);
    chk(r[8:0], x[8:0]);
    repeat (x + 3) begin
      seed = nxt(seed);
      xfer(1'h0, seed[17:0]);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    chk({hff, alf, irf, orf}, 4'h4);
    @(posedge clk);
    frst_n <= 1'h1;
    repeat (3) @(posedge clk);
    // two writes beyond capacity must be refused
    for (int i = 0; i < 1026; i++) begin
      seed = nxt(seed);
      xfer(1'h0, seed[17:0]);
    end
    ahb(1'h0, 32'h8, 32'h0);
    chk(r[10:0], 11'h400);
    ahb(1'h1, 32'h4, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'h1);
    ahb(1'h0, 32'h0, 32'h0);
    chk(r[0], 1'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'h0);
    ahb(1'h0, 32'h4, 32'h0);
    chk(r, 32'h1);
    ahb(1'h0, 32'h10, 32'h0);
    chk(r, 32'h0);
    // one read beyond empty must be refused
    repeat (1025) xfer(1'h1, 18'h0);
    seed = nxt(seed);
    x = seed[3:0];
    wd <= {seed[17:9], 5'h0, seed[3:0]};
    @(posedge clk);
    prog(1'h0);
    prog(1'h0);
    x = 256;
    prog(1'h1);
    close_out();
  end
endmodule
